// >>> include/idm_pkg.sv
// Shared constants and helpers for the indirect data memory access block.
`default_nettype none

package idm_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Widths of the data memory access path.
  localparam int ADDR_W  = 10;
  localparam int DATA_W  = 8;
  localparam int SEC_W   = 2;
  localparam int OFF_W   = 8;
  localparam int PTR_NUM = 5;

  //////////////////////////////////////////////////////////////////////////
  // Sector 0 offsets of the windows and pointer bytes.
  localparam logic [7:0] OFF_WIN_ZERO   = 8'h00;
  localparam logic [7:0] OFF_PTR_ZERO   = 8'h01;
  localparam logic [7:0] OFF_WIN_ONE    = 8'h02;
  localparam logic [7:0] OFF_PTR_ONE_L  = 8'h03;
  localparam logic [7:0] OFF_PTR_ONE_S  = 8'h04;
  localparam logic [7:0] OFF_WIN_TWO    = 8'h0C;
  localparam logic [7:0] OFF_PTR_TWO_L  = 8'h0D;
  localparam logic [7:0] OFF_PTR_TWO_S  = 8'h0E;

  // First offset of the general purpose area within every sector.
  localparam logic [7:0] OFF_GP_BASE    = 8'h80;

  // Reset value of the pointers and the value read from empty locations.
  localparam logic [7:0] PTR_RESET      = 8'h00;
  localparam logic [7:0] READ_EMPTY     = 8'h00;

  // Indices of the pointer bytes in the pointer bank.
  localparam logic [2:0] IDX_PTR_ZERO   = 3'h0;
  localparam logic [2:0] IDX_PTR_ONE_L  = 3'h1;
  localparam logic [2:0] IDX_PTR_ONE_S  = 3'h2;
  localparam logic [2:0] IDX_PTR_TWO_L  = 3'h3;
  localparam logic [2:0] IDX_PTR_TWO_S  = 3'h4;
  localparam logic [2:0] IDX_NONE       = 3'h7;

  // What an effective address lands on.
  typedef enum logic [1:0]
  {
    IDM_TGT_NONE = 2'h0,
    IDM_TGT_PTR  = 2'h1,
    IDM_TGT_RAM  = 2'h2
  } idm_target_type;

  //////////////////////////////////////////////////////////////////////////
  // True for any of the three virtual window offsets.
  function automatic logic idm_is_window(input logic [7:0] off);
    idm_is_window = (off == OFF_WIN_ZERO) || (off == OFF_WIN_ONE) ||
                    (off == OFF_WIN_TWO);
  endfunction : idm_is_window

  // Pointer bank index of a sector 0 offset, IDX_NONE when not a pointer.
  function automatic logic [2:0] idm_ptr_index(input logic [7:0] off);
    case (off)
      OFF_PTR_ZERO:  idm_ptr_index = IDX_PTR_ZERO;
      OFF_PTR_ONE_L: idm_ptr_index = IDX_PTR_ONE_L;
      OFF_PTR_ONE_S: idm_ptr_index = IDX_PTR_ONE_S;
      OFF_PTR_TWO_L: idm_ptr_index = IDX_PTR_TWO_L;
      OFF_PTR_TWO_S: idm_ptr_index = IDX_PTR_TWO_S;
      default:       idm_ptr_index = IDX_NONE;
    endcase
  endfunction : idm_ptr_index

endpackage : idm_pkg

`default_nettype wire

// >>> rtl/idm_data_ram.sv
// General purpose data memory: one block of bytes per sector.
`timescale 1ns/10ps
`default_nettype none

module idm_data_ram
  import idm_pkg::*;
#(
  parameter int SECTORS  = 4,
  parameter int GP_DEPTH = 128
)
(
  input  wire logic              i_core_clk,
  input  wire logic              i_we,
  input  wire logic [SEC_W-1:0]  i_sector,
  input  wire logic [6:0]        i_offset,
  input  wire logic [DATA_W-1:0] i_wdata,
  output logic      [DATA_W-1:0] o_rdata
);

  // The array carries no reset, as real data memory powers up unknown.
  logic [DATA_W-1:0] mem [SECTORS*GP_DEPTH];
  logic [8:0]        index;

  // Sector picks the block, the low offset bits pick the byte in it.
  assign index   = {i_sector, i_offset};
  assign o_rdata = mem[index];

  // Writes land on the clock edge; reads are combinational.
  always_ff @(posedge i_core_clk)
  begin
    if (i_we)
    begin
      mem[index] <= i_wdata;
    end
  end

endmodule : idm_data_ram

`default_nettype wire

// >>> rtl/idm_addr_resolve.sv
// Turns a core data address into an effective sector, offset and target.
`timescale 1ns/10ps
`default_nettype none

module idm_addr_resolve
  import idm_pkg::*;
#(
  parameter int SECTORS = 4
)
(
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic              i_ext,
  input  wire logic [7:0]        i_ptr_zero,
  input  wire logic [7:0]        i_ptr_one_l,
  input  wire logic [7:0]        i_ptr_one_s,
  input  wire logic [7:0]        i_ptr_two_l,
  input  wire logic [7:0]        i_ptr_two_s,
  output logic      [SEC_W-1:0]  o_sector,
  output logic      [OFF_W-1:0]  o_offset,
  output idm_target_type         o_target,
  output logic                   o_redirect
);

  logic [7:0] dir_sec;
  logic [7:0] eff_sec;
  logic [7:0] eff_off;

  // Standard instructions see sector 0 only; extended ones carry a sector.
  assign dir_sec = i_ext ? {6'h00, i_addr[9:8]} : 8'h00;

  // Windows in sector 0 are swapped for their pointer's address. The
  // result is never resolved again, so a window cannot chain to another.
  always_comb
  begin
    eff_sec    = dir_sec;
    eff_off    = i_addr[7:0];
    o_redirect = 1'b0;
    if (dir_sec == 8'h00)
    begin
      if (i_addr[7:0] == OFF_WIN_ZERO)
      begin
        eff_sec    = 8'h00;
        eff_off    = i_ptr_zero;
        o_redirect = 1'b1;
      end
      else if (i_addr[7:0] == OFF_WIN_ONE)
      begin
        eff_sec    = i_ptr_one_s;
        eff_off    = i_ptr_one_l;
        o_redirect = 1'b1;
      end
      else if (i_addr[7:0] == OFF_WIN_TWO)
      begin
        eff_sec    = i_ptr_two_s;
        eff_off    = i_ptr_two_l;
        o_redirect = 1'b1;
      end
    end
  end

  // Class of the effective location; sectors past the last one are empty.
  always_comb
  begin
    if (eff_sec >= 8'(SECTORS))
      o_target = IDM_TGT_NONE;
    else if (eff_off >= OFF_GP_BASE)
      o_target = IDM_TGT_RAM;
    else if ((eff_sec == 8'h00) && (idm_ptr_index(eff_off) != IDX_NONE))
      o_target = IDM_TGT_PTR;
    else
      o_target = IDM_TGT_NONE;
  end

  assign o_sector = eff_sec[SEC_W-1:0];
  assign o_offset = eff_off;

endmodule : idm_addr_resolve

`default_nettype wire

// >>> rtl/idm_indirect_access.sv
// Indirect data memory access: windows, pointer bank and data memory.
`timescale 1ns/10ps
`default_nettype none

module idm_indirect_access
  import idm_pkg::*;
#(
  parameter int SECTORS = 4
)
(
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  input  wire logic              i_acc_valid,
  input  wire logic              i_acc_write,
  input  wire logic              i_acc_ext,
  input  wire logic [ADDR_W-1:0] i_acc_addr,
  input  wire logic [DATA_W-1:0] i_acc_wdata,
  output logic      [DATA_W-1:0] o_rd_data,
  output logic                   o_rd_valid,
  output logic      [ADDR_W-1:0] o_eff_addr,
  output logic                   o_redirect
);

  ////////////////////////////////////////////////////////////////////////////
  // Pointer bank and resolved address.

  logic [7:0]          ptr [PTR_NUM];
  logic [SEC_W-1:0]    eff_sector;
  logic [OFF_W-1:0]    eff_offset;
  idm_target_type      eff_target;
  logic                res_redirect;
  logic [2:0]          eff_index;
  logic [DATA_W-1:0]   ram_rdata;
  logic                ram_we;
  logic [DATA_W-1:0]   next_rd_data;

  // The resolver sees the live pointers, so a pointer written in one cycle
  // steers a window access in the very next one.
  idm_addr_resolve #(
    .SECTORS    (SECTORS)
  ) u_resolve (
    .i_addr     (i_acc_addr),
    .i_ext      (i_acc_ext),
    .i_ptr_zero (ptr[IDX_PTR_ZERO]),
    .i_ptr_one_l(ptr[IDX_PTR_ONE_L]),
    .i_ptr_one_s(ptr[IDX_PTR_ONE_S]),
    .i_ptr_two_l(ptr[IDX_PTR_TWO_L]),
    .i_ptr_two_s(ptr[IDX_PTR_TWO_S]),
    .o_sector   (eff_sector),
    .o_offset   (eff_offset),
    .o_target   (eff_target),
    .o_redirect (res_redirect)
  );

  assign eff_index = idm_ptr_index(eff_offset);

  ////////////////////////////////////////////////////////////////////////////
  // Pointer registers: each one a plain byte, reached directly or through
  // a window, so read-modify-write instructions work on them as usual.

  generate
    for (genvar g = 0; g < PTR_NUM; g++)
    begin : g_ptr
      always_ff @(posedge i_core_clk or posedge i_rst)
      begin
        if (i_rst)
          ptr[g] <= PTR_RESET;
        else if (i_acc_valid && i_acc_write &&
                 (eff_target == IDM_TGT_PTR) &&
                 (eff_index == 3'(g)))
          ptr[g] <= i_acc_wdata;
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // General purpose memory of all sectors.

  // Writes to windows resolved as physical locations or to empty locations fall through with no effect.
  assign ram_we = i_acc_valid && i_acc_write &&
                  (eff_target == IDM_TGT_RAM);

  idm_data_ram #(
    .SECTORS (SECTORS),
    .GP_DEPTH(128)
  ) u_ram (
    .i_core_clk(i_core_clk),
    .i_we      (ram_we),
    .i_sector  (eff_sector),
    .i_offset  (eff_offset[6:0]),
    .i_wdata   (i_acc_wdata),
    .o_rdata   (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection. Windows resolved as physical locations and every
  // location this block does not hold give the empty value.

  always_comb
  begin
    unique case (eff_target)
      IDM_TGT_RAM: next_rd_data = ram_rdata;
      IDM_TGT_PTR: next_rd_data = ptr[eff_index];
      default:     next_rd_data = READ_EMPTY;
    endcase
  end

  // Read answer one edge after the request.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_rd_data  <= READ_EMPTY;
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_acc_valid && !i_acc_write;
      if (i_acc_valid && !i_acc_write)
        o_rd_data <= next_rd_data;
    end
  end

  // Effective address of the last access, kept for tracing.
  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_eff_addr <= '0;
      o_redirect <= 1'b0;
    end
    else if (i_acc_valid)
    begin
      o_eff_addr <= {eff_sector, eff_offset};
      o_redirect <= res_redirect;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the behaviour above.

  // All checks run on the core clock and sleep while reset is high, so
  // values sampled during reset only ever feed $past on the first edge.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_rst);

  // Standard instruction aimed at one window.
  sequence win_access_s(logic [7:0] off);
    i_acc_valid && !i_acc_ext && (i_acc_addr[7:0] == off);
  endsequence

  // A pointer write followed at once by a read of the same pointer.
  sequence ptr_write_read_s;
    i_acc_valid && i_acc_write && !i_acc_ext &&
    (i_acc_addr[7:0] == OFF_PTR_ONE_L) ##1
    i_acc_valid && !i_acc_write && !i_acc_ext &&
    (i_acc_addr[7:0] == OFF_PTR_ONE_L);
  endsequence

  win_zero_redirect_a: assert property (
    win_access_s(OFF_WIN_ZERO) |=>
      o_redirect && (o_eff_addr == {2'b00, $past(ptr[IDX_PTR_ZERO])}))
    else $error("window zero not redirected to its pointer");

  win_zero_sector_a: assert property (
    win_access_s(OFF_WIN_ZERO) |=> (o_eff_addr[ADDR_W-1:8] == 2'b00))
    else $error("window zero left sector 0");

  win_one_reach_a: assert property (
    win_access_s(OFF_WIN_ONE) |=>
      o_eff_addr == {$past(ptr[IDX_PTR_ONE_S][1:0]),
                     $past(ptr[IDX_PTR_ONE_L])})
    else $error("window one effective address wrong");

  win_two_reach_a: assert property (
    win_access_s(OFF_WIN_TWO) |=>
      o_eff_addr == {$past(ptr[IDX_PTR_TWO_S][1:0]),
                     $past(ptr[IDX_PTR_TWO_L])})
    else $error("window two effective address wrong");

  sector_byte_split_a: assert property (
    win_access_s(OFF_WIN_TWO) ##1 1'b1 |->
      o_eff_addr[7:0] == $past(ptr[IDX_PTR_TWO_L], 1) &&
      o_eff_addr[9:8] == $past(ptr[IDX_PTR_TWO_S][1:0], 1))
    else $error("sector and location bytes swapped");

  ptr_only_source_a: assert property (
    win_access_s(OFF_WIN_ZERO) ##1
    win_access_s(OFF_WIN_ZERO) ##0 $stable(ptr[IDX_PTR_ZERO])
      |=> $stable(o_eff_addr))
    else $error("effective address moved with pointer unchanged");

  window_read_empty_a: assert property (
    win_access_s(OFF_WIN_ZERO) ##0
    (!i_acc_write && idm_is_window(ptr[IDX_PTR_ZERO]))
      |=> o_rd_valid && (o_rd_data == 8'h00))
    else $error("window read as a location not empty");

  window_write_noop_a: assert property (
    win_access_s(OFF_WIN_ZERO) ##0
    (i_acc_write && idm_is_window(ptr[IDX_PTR_ZERO])) |=>
      $stable(ptr[IDX_PTR_ZERO]) && $stable(ptr[IDX_PTR_ONE_L]) &&
      $stable(ptr[IDX_PTR_ONE_S]) && $stable(ptr[IDX_PTR_TWO_L]) &&
      $stable(ptr[IDX_PTR_TWO_S]))
    else $error("write to a window location changed a pointer");

  ptr_readback_a: assert property (
    ptr_write_read_s |=> o_rd_valid && (o_rd_data == $past(i_acc_wdata, 2)))
    else $error("pointer did not read back the value written");

  ext_direct_a: assert property (
    i_acc_valid && i_acc_ext && (i_acc_addr[9:8] != 2'b00) |=>
      !o_redirect && (o_eff_addr == $past(i_acc_addr)))
    else $error("extended access not direct");

  ext_decode_a: assert property (
    i_acc_valid && i_acc_ext && !idm_is_window(i_acc_addr[7:0]) |=>
      o_eff_addr[9:8] == $past(i_acc_addr[9:8]) &&
      o_eff_addr[7:0] == $past(i_acc_addr[7:0]))
    else $error("extended address decoded wrongly");

  unused_empty_a: assert property (
    i_acc_valid && !i_acc_write && (i_acc_addr[7:0] < OFF_GP_BASE) &&
    !idm_is_window(i_acc_addr[7:0]) &&
    (idm_ptr_index(i_acc_addr[7:0]) == IDX_NONE)
      |=> o_rd_valid && (o_rd_data == READ_EMPTY))
    else $error("unused location did not read 00H");

  ptr_zero_full_a: assert property (
    win_access_s(OFF_WIN_ZERO) ##0 ptr[IDX_PTR_ZERO][7] |=>
      o_eff_addr[7] && (o_eff_addr[6:0] == $past(ptr[IDX_PTR_ZERO][6:0])))
    else $error("sector 0 pointer not used as a full byte");

  rd_valid_pulse_a: assert property (
    i_acc_valid && i_acc_write |=> !o_rd_valid)
    else $error("read answer after a write");

  // A direct write of the sector 0 pointer, then window zero at once.
  sequence ptr_write_win_s;
    i_acc_valid && i_acc_write && !i_acc_ext &&
    (i_acc_addr[7:0] == OFF_PTR_ZERO) ##1
    win_access_s(OFF_WIN_ZERO);
  endsequence

  // The live pointer steers a window access in the very next cycle.
  ptr_write_win_a: assert property (
    ptr_write_win_s |=>
      o_redirect && (o_eff_addr == {2'b00, $past(i_acc_wdata, 2)}))
    else $error("fresh pointer value did not steer window zero");

  // A sector byte past the last sector makes window one read empty.
  win_one_range_a: assert property (
    win_access_s(OFF_WIN_ONE) ##0
    (!i_acc_write && (ptr[IDX_PTR_ONE_S] >= 8'(SECTORS)))
      |=> o_rd_valid && (o_rd_data == READ_EMPTY))
    else $error("window one read outside the sectors not empty");

  // A direct write lands in the pointer byte at the next edge.
  ptr_direct_write_a: assert property (
    i_acc_valid && i_acc_write && !i_acc_ext &&
    (i_acc_addr[7:0] == OFF_PTR_TWO_S) |=>
      ptr[IDX_PTR_TWO_S] == $past(i_acc_wdata))
    else $error("direct write missed the pointer byte");

  // Standard instructions ignore the upper address bits.
  std_sector_zero_a: assert property (
    i_acc_valid && !i_acc_ext && !idm_is_window(i_acc_addr[7:0]) |=>
      !o_redirect && (o_eff_addr == {2'b00, $past(i_acc_addr[7:0])}))
    else $error("standard access left sector 0");

  // Every read request is answered one edge later.
  rd_valid_read_a: assert property (
    i_acc_valid && !i_acc_write |=> o_rd_valid)
    else $error("read request not answered");

  // No answer appears in a cycle that follows no read request.
  rd_valid_idle_a: assert property (
    !(i_acc_valid && !i_acc_write) |=> !o_rd_valid)
    else $error("read answer without a read request");

  // The traced address and flag stand until the next access.
  eff_addr_hold_a: assert property (
    !i_acc_valid |=> $stable(o_eff_addr) && $stable(o_redirect))
    else $error("traced address moved without an access");

  // Read data stands until the next read, so a slow reader still sees it.
  rd_data_hold_a: assert property (
    !(i_acc_valid && !i_acc_write) |=> $stable(o_rd_data))
    else $error("read data moved without a read");

endmodule : idm_indirect_access

`default_nettype wire

// >>> testbench/idm_core_model.sv
// Behavioural model of the core that issues data memory accesses.
`timescale 1ns/10ps
`default_nettype none

module idm_core_model
  import idm_pkg::*;
(
  input  wire logic              i_core_clk,
  output logic                   o_acc_valid,
  output logic                   o_acc_write,
  output logic                   o_acc_ext,
  output logic      [ADDR_W-1:0] o_acc_addr,
  output logic      [DATA_W-1:0] o_acc_wdata
);

  // Quiet bus at time zero.
  initial
  begin
    o_acc_valid = 1'b0;
    o_acc_write = 1'b0;
    o_acc_ext   = 1'b0;
    o_acc_addr  = 10'h000;
    o_acc_wdata = 8'h00;
  end

  //////////////////////////////////////////////////////////////////////////
  // One access, launched on the falling edge and held for one cycle.
  task automatic access(input logic              wr,
                        input logic              ext,
                        input logic [ADDR_W-1:0] addr,
                        input logic [DATA_W-1:0] wdata);
    @(negedge i_core_clk);
    o_acc_valid = 1'b1;
    o_acc_write = wr;
    o_acc_ext   = ext;
    o_acc_addr  = addr;
    o_acc_wdata = wdata;
  endtask : access

  // Idle cycles drop valid and flip write, address and data, so stale values never look valid.
  task automatic idle(input int cycles);
    repeat (cycles)
    begin
      @(negedge i_core_clk);
      o_acc_valid = 1'b0;
      o_acc_write = ~o_acc_write;
      o_acc_addr  = ~o_acc_addr;
      o_acc_wdata = ~o_acc_wdata;
    end
  endtask : idle

endmodule : idm_core_model

`default_nettype wire

// >>> testbench/idm_indirect_access_test.sv
// Self-checking bench for the indirect data memory access block.
`timescale 1ns/10ps
`default_nettype none

module idm_indirect_access_test;
  import idm_pkg::*;

  // One expected read answer; chk_eff off where the address is a choice.
  typedef struct packed
  {
    logic [7:0] data;
    logic [9:0] eff;
    logic       redir;
    logic       chk_eff;
  } idm_exp_type;

  logic              i_core_clk = 1'b0;
  logic              i_rst      = 1'b1;
  logic              acc_valid;
  logic              acc_write;
  logic              acc_ext;
  logic [ADDR_W-1:0] acc_addr;
  logic [DATA_W-1:0] acc_wdata;
  logic [DATA_W-1:0] o_rd_data;
  logic              o_rd_valid;
  logic [ADDR_W-1:0] o_eff_addr;
  logic              o_redirect;
  idm_exp_type       exp_q[$];
  idm_exp_type       e;
  logic [7:0]        lfsr = 8'h0F;
  logic [7:0]        gp [4][8];
  logic [7:0]        ptr_off [5] = '{8'h01, 8'h03, 8'h04, 8'h0D, 8'h0E};
  logic [7:0]        v;
  int                num_errors = 0;
  int                compares   = 0;

  always #5 i_core_clk = ~i_core_clk;

  idm_core_model u_core
  (
    .i_core_clk  (i_core_clk),
    .o_acc_valid (acc_valid),
    .o_acc_write (acc_write),
    .o_acc_ext   (acc_ext),
    .o_acc_addr  (acc_addr),
    .o_acc_wdata (acc_wdata)
  );

  idm_indirect_access #(.SECTORS(4)) u_dut
  (
    .i_core_clk  (i_core_clk),
    .i_rst       (i_rst),
    .i_acc_valid (acc_valid),
    .i_acc_write (acc_write),
    .i_acc_ext   (acc_ext),
    .i_acc_addr  (acc_addr),
    .i_acc_wdata (acc_wdata),
    .o_rd_data   (o_rd_data),
    .o_rd_valid  (o_rd_valid),
    .o_eff_addr  (o_eff_addr),
    .o_redirect  (o_redirect)
  );

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [9:0] seen,
                       input logic [9:0] expv);
    compares++;
    if (seen !== expv)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd

  task automatic wr(input logic ext, input logic [9:0] a, input logic [7:0] d);
    u_core.access(1'b1, ext, a, d);
  endtask : wr

  // The note goes in before the request, so it is queued ahead of its answer.
  task automatic rd(input logic ext, input logic [9:0] a, input logic [7:0] d,
                    input logic [9:0] eff, input logic rdr, input logic ce);
    exp_q.push_back('{d, eff, rdr, ce});
    u_core.access(1'b0, ext, a, 8'h00);
  endtask : rd

  task automatic end_test(input string name);
    u_core.idle(3);
    $display("Test %s done", name);
  endtask : end_test

  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : finish_test

  //////////////////////////////////////////////////////////////////////////
  // Outputs are settled at the falling edge; each pulse takes one note.
  always @(negedge i_core_clk)
  begin
    if (o_rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("rd_valid", 10'h001, 10'h000);
      else
      begin
        e = exp_q.pop_front();
        check("rd_data", {2'b00, o_rd_data}, {2'b00, e.data});
        check("redirect", {9'h000, o_redirect}, {9'h000, e.redir});
        if (e.chk_eff)
          check("eff_addr", o_eff_addr, e.eff);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (8) @(posedge i_core_clk);
    @(negedge i_core_clk);
    i_rst = 1'b0;
    // Cleared pointers; window one then lands on window zero and reads empty.
    foreach (ptr_off[i])
      rd(1'b0, {2'b00, ptr_off[i]}, 8'h00, {2'b00, ptr_off[i]}, 1'b0, 1'b1);
    rd(1'b0, 10'h002, 8'h00, 10'h000, 1'b1, 1'b0);
    end_test("reset");
    // Pointers written twice back to back keep the last byte.
    foreach (ptr_off[i])
    begin
      v = rnd();
      wr(1'b0, {2'b00, ptr_off[i]}, v);
      wr(1'b0, {2'b00, ptr_off[i]}, v + 8'h01);
      rd(1'b0, {2'b00, ptr_off[i]}, v + 8'h01, {2'b00, ptr_off[i]}, 1'b0, 1'b1);
    end
    end_test("pointers");
    // Extended writes and reads reach every sector directly.
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 8; k++)
      begin
        gp[s][k] = rnd();
        wr(1'b1, {s[1:0], 8'h80 + k[7:0]}, gp[s][k]);
      end
    for (int s = 0; s < 4; s++)
      for (int k = 0; k < 8; k++)
        rd(1'b1, {s[1:0], 8'h80 + k[7:0]}, gp[s][k],
           {s[1:0], 8'h80 + k[7:0]}, 1'b0, 1'b1);
    rd(1'b0, 10'h385, gp[0][5], 10'h085, 1'b0, 1'b1);
    end_test("direct");
    // Both sector-spanning windows, each with its own pointer pair.
    for (int s = 0; s < 4; s++)
    begin
      wr(1'b0, 10'h004, {6'h00, s[1:0]});
      wr(1'b0, 10'h003, 8'h80 + s[7:0]);
      wr(1'b0, 10'h00E, {6'h00, 2'd3 - s[1:0]});
      wr(1'b0, 10'h00D, 8'h87 - s[7:0]);
      rd(1'b0, 10'h002, gp[s][s], {s[1:0], 8'h80 + s[7:0]}, 1'b1, 1'b1);
      rd(1'b0, 10'h00C, gp[3-s][7-s],
         {2'd3 - s[1:0], 8'h87 - s[7:0]}, 1'b1, 1'b1);
    end
    wr(1'b0, 10'h004, 8'h04);
    rd(1'b0, 10'h002, 8'h00, 10'h000, 1'b1, 1'b0);
    end_test("windows");
    // Window zero stays in sector 0 whatever the other pointers hold.
    wr(1'b0, 10'h001, 8'h83);
    wr(1'b0, 10'h004, 8'h02);
    rd(1'b0, 10'h000, gp[0][3], 10'h083, 1'b1, 1'b1);
    // A write through a window lands at the pointed location.
    wr(1'b0, 10'h00E, 8'h02);
    wr(1'b0, 10'h00D, 8'h81);
    v = rnd();
    wr(1'b0, 10'h00C, v);
    rd(1'b1, 10'h281, v, 10'h281, 1'b0, 1'b1);
    end_test("redirect");
    // A window pointed at itself, and unused places, store nothing.
    wr(1'b0, 10'h001, 8'h00);
    wr(1'b0, 10'h000, 8'hA5);
    rd(1'b0, 10'h000, 8'h00, 10'h000, 1'b1, 1'b0);
    rd(1'b0, 10'h001, 8'h00, 10'h001, 1'b0, 1'b1);
    wr(1'b1, 10'h120, 8'h5A);
    wr(1'b0, 10'h020, 8'h3C);
    rd(1'b1, 10'h120, 8'h00, 10'h120, 1'b0, 1'b1);
    rd(1'b0, 10'h020, 8'h00, 10'h020, 1'b0, 1'b1);
    end_test("empty");
    // A reset in mid-run clears the outputs and the pointer byte at 0DH again.
    @(negedge i_core_clk);
    i_rst = 1'b1;
    repeat (2) @(negedge i_core_clk);
    check("rst_rd_valid", {9'h000, o_rd_valid}, 10'h000);
    check("rst_rd_data", {2'b00, o_rd_data}, 10'h000);
    check("rst_eff_addr", o_eff_addr, 10'h000);
    check("rst_redirect", {9'h000, o_redirect}, 10'h000);
    i_rst = 1'b0;
    rd(1'b0, 10'h00D, 8'h00, 10'h00D, 1'b0, 1'b1);
    end_test("reset again");
    // Every note must have been answered within a few cycles.
    for (int w = 0; w < 10 && exp_q.size() != 0; w++)
      @(negedge i_core_clk);
    check("pending", 10'(exp_q.size()), 10'h000);
    finish_test();
  end

endmodule : idm_indirect_access_test

`default_nettype wire
